// ---- common/rlsc_pkg.sv ----
// package for remote/local session control
// assumes one apb clock domain, 32-bit apb data
`default_nettype none
package rlsc_pkg;
  // ==========================================
  // register offsets
  localparam logic [7:0] RLSC_OFF_CTRL = 8'h00;
  localparam logic [7:0] RLSC_OFF_STATUS = 8'h04;
  localparam logic [7:0] RLSC_OFF_PORT = 8'h08;
  localparam logic [7:0] RLSC_OFF_GW_PEND = 8'h0c;
  localparam logic [7:0] RLSC_OFF_GW_ACT = 8'h10;
  localparam logic [7:0] RLSC_OFF_HWID_LO = 8'h14;
  localparam logic [7:0] RLSC_OFF_HWID_HI = 8'h18;
  localparam logic [7:0] RLSC_OFF_SERIAL = 8'h1c;
  localparam logic [7:0] RLSC_OFF_CMD = 8'h20;
  localparam logic [7:0] RLSC_OFF_MSGQ = 8'h24;
  // ==========================================
  // reset values and limits
  localparam logic [15:0] RLSC_PORT_DEFAULT = 16'h0da2;
  localparam logic [15:0] RLSC_PORT_MIN = 16'h0400;
  localparam logic [31:0] RLSC_GW_DEFAULT = 32'h0000_0000;
  localparam logic [17:0] RLSC_BAUD_MIN = 18'h0_012c;
  localparam logic [17:0] RLSC_BAUD_MAX = 18'h1_c200;
  localparam logic [17:0] RLSC_BAUD_DEFAULT = 18'h0_2580;
  localparam logic [3:0] RLSC_DATA_BITS_DEFAULT = 4'h8;
  localparam logic [1:0] RLSC_STOP_BITS_DEFAULT = 2'h1;
  localparam logic [1:0] RLSC_PARITY_DEFAULT = 2'h0;
  // ==========================================
  // field positions
  localparam int RLSC_CTRL_IF_LAN = 0;
  localparam int RLSC_CTRL_COMP_MODE = 1;
  localparam int RLSC_CTRL_GW_SEL = 2;
  localparam int RLSC_SER_BAUD_LSB = 0;
  localparam int RLSC_SER_DATA_LSB = 18;
  localparam int RLSC_SER_STOP_LSB = 22;
  localparam int RLSC_SER_PAR_LSB = 24;
  localparam int RLSC_ST_STATE_LSB = 0;
  localparam int RLSC_ST_SESS_LSB = 4;
  localparam int RLSC_ST_PANEL_EN = 8;
  localparam int RLSC_ST_MSG_PEND = 9;
  localparam int RLSC_ST_REJECTS_LSB = 16;
  // ==========================================
  // operating states
  typedef enum logic [3:0] {
    RLSC_LOCAL = 4'b0001,
    RLSC_REMOTE = 4'b0010,
    RLSC_LOCAL_LOCK = 4'b0100,
    RLSC_REMOTE_LOCK = 4'b1000
  } rlsc_op_t;
  // session states
  typedef enum logic [2:0] {
    RLSC_IDLE = 3'b001,
    RLSC_LISTEN = 3'b010,
    RLSC_CONNECTED = 3'b100
  } rlsc_sess_t;
  // state control commands, ascii words
  typedef enum logic [2:0] {
    RLSC_CMD_NONE = 3'h0,
    RLSC_CMD_REMOTE = 3'h1,
    RLSC_CMD_LOCAL = 3'h2,
    RLSC_CMD_LOCKOUT = 3'h3
  } rlsc_cmd_t;
  // network link events
  typedef struct packed {
    logic conn_req;
    logic client_close;
  } rlsc_net_in_t;
  typedef struct packed {
    logic listen;
    logic accept;
    logic reject;
    logic close;
    logic [15:0] port;
  } rlsc_net_out_t;
  // response path toward host
  typedef struct packed {
    logic valid;
    logic is_query;
    logic [7:0] data;
  } rlsc_resp_t;
endpackage
`default_nettype wire

// ---- logic/rlsc_top.sv ----
// remote/local session control with apb registers
// assumes apb master on pclk; net, panel, resp inputs synchronous to pclk
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - socket port resets to 3490 when no value configured
// - port writes outside 1024..65535 are dropped
// - new socket port drives the listener at once
// - port kept in nonvolatile store via restore inputs
// - gateway resets to zero, meaning no gateway
// - gateway change held pending until next power-up
// - off-network hosts are routed through the active gateway
// - hardware identifier is read only
// - selecting network interface starts listening on configured port
// - further connection requests rejected while a client is connected
// - leaving network interface closes the open session
// - client close returns to listening, network stays selected
// - local state accepts panel and executes remote commands
// - local goes remote on remote command, lockout on lockout command
// - remote command over serial or network enters remote
// - local lockout goes to remote lockout on remote command
// - remote ignores panel except release key; key or local gives local
// - remote lockout ignores every panel control incl release key
// - remote lockout plus local command goes to local lockout
// - command words decoded without regard to letter case
// - serial acts as terminal side, baud 300 to 115200
// - terminal mode returns responses and messages immediately
// - computer mode returns queries only, messages queued until read
// - serial defaults 9600 baud, 8 data, 1 stop, no parity
module rlsc_top #(
  parameter logic [47:0] HW_ID = 48'h0200_0000_0001, // arbitrary value
  parameter int MSGQ_DEPTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic nv_valid,
  input wire logic [15:0] nv_port,
  input wire logic [31:0] nv_gateway,
  output logic nv_port_wr,
  output logic [15:0] nv_port_data,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_char,
  input wire logic key_release,
  input wire logic panel_evt,
  input wire rlsc_pkg::rlsc_net_in_t net_in,
  output rlsc_pkg::rlsc_net_out_t net_out,
  input wire logic [31:0] host_addr,
  input wire logic [31:0] own_addr,
  input wire logic [31:0] net_mask,
  output logic [31:0] next_hop,
  input wire rlsc_pkg::rlsc_resp_t resp_in,
  output rlsc_pkg::rlsc_resp_t resp_out,
  output logic panel_accept,
  output logic terminal_side_serial_role
);
  import rlsc_pkg::*;
  // ==========================================
  // declarations
  rlsc_op_t op_reg;
  rlsc_sess_t sess_reg;
  logic [15:0] port_reg;
  logic [31:0] gw_pend_reg;
  logic [31:0] gw_act_reg;
  logic [25:0] serial_reg;
  logic if_lan_reg;
  logic comp_mode_reg;
  logic [15:0] rejects_reg;
  logic [55:0] word_reg;
  rlsc_cmd_t cmd_d;
  logic wr_en;
  logic rd_en;
  logic [7:0] msgq_mem [MSGQ_DEPTH];
  logic [$clog2(MSGQ_DEPTH+1)-1:0] msgq_cnt_reg;
  logic [$clog2(MSGQ_DEPTH)-1:0] msgq_rd_reg;
  logic [$clog2(MSGQ_DEPTH)-1:0] msgq_wr_reg;
  logic msg_push;
  logic msg_pop;
  logic [31:0] rd_data;
  logic [17:0] baud_w;

  // ==========================================
  // helpers
  function automatic logic [7:0] to_upper(input logic [7:0] c);
    if (c >= 8'h61 && c <= 8'h7a)
    begin
      return c - 8'h20;
    end
    return c;
  endfunction

  function automatic logic is_term(input logic [7:0] c);
    return (c == 8'h0d) || (c == 8'h0a) || (c == 8'h3b) || (c == 8'h20);
  endfunction

  // ==========================================
  // apb slave
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pslverr = 1'b0;
  assign baud_w = pwdata[RLSC_SER_BAUD_LSB +: 18];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_reg <= RLSC_PORT_DEFAULT;
    end
    else if (nv_valid)
    begin
      if (nv_port >= RLSC_PORT_MIN)
      begin
        port_reg <= nv_port;
      end
    end
    else if (wr_en && paddr == RLSC_OFF_PORT && pwdata[31:16] == 16'h0000 && pwdata[15:0] >= RLSC_PORT_MIN)
    begin
      port_reg <= pwdata[15:0];
    end
  end

  assign nv_port_wr = wr_en && !nv_valid && paddr == RLSC_OFF_PORT && pwdata[31:16] == 16'h0000
    && pwdata[15:0] >= RLSC_PORT_MIN;
  assign nv_port_data = pwdata[15:0];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gw_pend_reg <= RLSC_GW_DEFAULT;
    end
    else if (nv_valid)
    begin
      gw_pend_reg <= nv_gateway;
    end
    else if (wr_en && paddr == RLSC_OFF_GW_PEND)
    begin
      gw_pend_reg <= pwdata;
    end
  end

  // active gateway loads only on power-up restore
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gw_act_reg <= RLSC_GW_DEFAULT;
    end
    else if (nv_valid)
    begin
      gw_act_reg <= nv_gateway;
    end
  end

  // off-network hosts via gateway, zero means none
  assign next_hop = (((host_addr ^ own_addr) & net_mask) != 32'h0000_0000 && gw_act_reg != RLSC_GW_DEFAULT)
    ? gw_act_reg : host_addr;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      if_lan_reg <= 1'b0;
      comp_mode_reg <= 1'b1;
    end
    else if (wr_en && paddr == RLSC_OFF_CTRL)
    begin
      if_lan_reg <= pwdata[RLSC_CTRL_IF_LAN];
      comp_mode_reg <= pwdata[RLSC_CTRL_COMP_MODE];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      serial_reg <= {RLSC_PARITY_DEFAULT, RLSC_STOP_BITS_DEFAULT, RLSC_DATA_BITS_DEFAULT,
        RLSC_BAUD_DEFAULT};
    end
    else if (wr_en && paddr == RLSC_OFF_SERIAL && baud_w >= RLSC_BAUD_MIN && baud_w <= RLSC_BAUD_MAX)
    begin
      serial_reg <= pwdata[25:0];
    end
  end

  assign terminal_side_serial_role = 1'b1;

  // ==========================================
  // command word decoder, last seven characters of the word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      word_reg <= 56'h00_0000_0000_0000;
    end
    else if (cmd_valid)
    begin
      word_reg <= is_term(cmd_char) ? 56'h00_0000_0000_0000 : {word_reg[47:0], to_upper(cmd_char)};
    end
  end

  always_comb
  begin
    cmd_d = RLSC_CMD_NONE;
    if (cmd_valid && is_term(cmd_char))
    begin
      case (word_reg)
        56'h00_5245_4d4f_5445: cmd_d = RLSC_CMD_REMOTE;
        56'h00_004c_4f43_414c: cmd_d = RLSC_CMD_LOCAL;
        56'h4c_4f43_4b4f_5554: cmd_d = RLSC_CMD_LOCKOUT;
        default: cmd_d = RLSC_CMD_NONE;
      endcase
    end
  end

  // ==========================================
  // operating state machine

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      op_reg <= RLSC_LOCAL;
    end
    else
    begin
      unique case (op_reg)
        RLSC_LOCAL:
          if (cmd_d == RLSC_CMD_REMOTE)
            op_reg <= RLSC_REMOTE;
          else if (cmd_d == RLSC_CMD_LOCKOUT)
            op_reg <= RLSC_LOCAL_LOCK;
        RLSC_REMOTE:
          if (cmd_d == RLSC_CMD_LOCAL || key_release)
            op_reg <= RLSC_LOCAL;
          else if (cmd_d == RLSC_CMD_LOCKOUT)
            op_reg <= RLSC_REMOTE_LOCK;
        RLSC_LOCAL_LOCK:
          if (cmd_d == RLSC_CMD_REMOTE)
            op_reg <= RLSC_REMOTE_LOCK;
          else if (cmd_d == RLSC_CMD_LOCAL)
            op_reg <= RLSC_LOCAL;
        RLSC_REMOTE_LOCK:
          if (cmd_d == RLSC_CMD_LOCAL)
            op_reg <= RLSC_LOCAL_LOCK;
        default: op_reg <= RLSC_LOCAL;
      endcase
    end
  end

  assign panel_accept = panel_evt && (op_reg == RLSC_LOCAL || op_reg == RLSC_LOCAL_LOCK);

  // ==========================================
  // socket session
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sess_reg <= RLSC_IDLE;
    end
    else
    begin
      unique case (sess_reg)
        RLSC_IDLE:
          if (if_lan_reg)
            sess_reg <= RLSC_LISTEN;
        RLSC_LISTEN:
          if (!if_lan_reg)
            sess_reg <= RLSC_IDLE;
          else if (net_in.conn_req)
            sess_reg <= RLSC_CONNECTED;
        RLSC_CONNECTED:
          if (!if_lan_reg)
            sess_reg <= RLSC_IDLE;
          else if (net_in.client_close)
            sess_reg <= RLSC_LISTEN;
        default: sess_reg <= RLSC_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rejects_reg <= 16'h0000;
    end
    else if (sess_reg == RLSC_CONNECTED && net_in.conn_req && rejects_reg != 16'hffff)
    begin
      rejects_reg <= rejects_reg + 16'h0001;
    end
  end

  always_comb
  begin
    net_out.listen = (sess_reg == RLSC_LISTEN);
    net_out.accept = (sess_reg == RLSC_LISTEN) && if_lan_reg && net_in.conn_req;
    net_out.reject = (sess_reg == RLSC_CONNECTED) && net_in.conn_req;
    net_out.close = (sess_reg == RLSC_CONNECTED) && !if_lan_reg;
    net_out.port = port_reg;
  end

  // ==========================================
  // response routing and message queue
  assign msg_push = resp_in.valid && !resp_in.is_query && comp_mode_reg
    && msgq_cnt_reg != MSGQ_DEPTH[$bits(msgq_cnt_reg)-1:0];
  assign msg_pop = rd_en && paddr == RLSC_OFF_MSGQ && msgq_cnt_reg != '0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      msgq_cnt_reg <= '0;
      msgq_rd_reg <= '0;
      msgq_wr_reg <= '0;
    end
    else
    begin
      if (msg_push)
        msgq_wr_reg <= msgq_wr_reg + 1'b1;
      if (msg_pop)
        msgq_rd_reg <= msgq_rd_reg + 1'b1;
      if (msg_push && !msg_pop)
        msgq_cnt_reg <= msgq_cnt_reg + 1'b1;
      else if (msg_pop && !msg_push)
        msgq_cnt_reg <= msgq_cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge pclk)
  begin
    if (msg_push)
    begin
      msgq_mem[msgq_wr_reg] <= resp_in.data;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      resp_out <= '0;
    end
    else
    begin
      resp_out.valid <= resp_in.valid && (!comp_mode_reg || resp_in.is_query);
      resp_out.is_query <= resp_in.is_query;
      resp_out.data <= resp_in.data;
    end
  end

  // ==========================================
  // read mux
  always_comb
  begin
    rd_data = 32'h0000_0000;
    unique case (paddr)
      RLSC_OFF_CTRL: rd_data = {30'h0000_0000, comp_mode_reg, if_lan_reg};
      RLSC_OFF_STATUS: rd_data = {rejects_reg, 6'h00, msgq_cnt_reg != '0, panel_accept | (op_reg[0] | op_reg[2]),
        1'b0, sess_reg, op_reg};
      RLSC_OFF_PORT: rd_data = {16'h0000, port_reg};
      RLSC_OFF_GW_PEND: rd_data = gw_pend_reg;
      RLSC_OFF_GW_ACT: rd_data = gw_act_reg;
      RLSC_OFF_HWID_LO: rd_data = HW_ID[31:0];
      RLSC_OFF_HWID_HI: rd_data = {16'h0000, HW_ID[47:32]};
      RLSC_OFF_SERIAL: rd_data = {6'h00, serial_reg};
      RLSC_OFF_MSGQ: rd_data = {24'h00_0000, msgq_mem[msgq_rd_reg]};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (psel && !penable && !pwrite)
    begin
      prdata <= rd_data;
    end
  end
endmodule
`default_nettype wire

// ---- tb/rlsc_top_assertions.sv ----
// checker for the session control top ports
// assumes bind onto rlsc_top, one pclk domain
`timescale 1ns/1ns
`default_nettype none
module rlsc_chk #(
  parameter int MSGQ_DEPTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic nv_port_wr,
  input wire logic [15:0] nv_port_data,
  input wire logic panel_evt,
  input wire logic panel_accept,
  input wire rlsc_pkg::rlsc_net_in_t net_in,
  input wire rlsc_pkg::rlsc_net_out_t net_out,
  input wire logic [31:0] host_addr,
  input wire logic [31:0] own_addr,
  input wire logic [31:0] net_mask,
  input wire logic [31:0] next_hop,
  input wire rlsc_pkg::rlsc_resp_t resp_in,
  input wire rlsc_pkg::rlsc_resp_t resp_out,
  input wire logic terminal_side_serial_role
);
  import rlsc_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ==========
  // session steps
  sequence req_listen_s;
    net_out.listen && net_in.conn_req;
  endsequence
  sequence taken_s;
    net_out.accept ##1 !net_out.listen;
  endsequence
  // ==========
  // checks
  port_reset_a: assert property ($rose(presetn) |-> net_out.port == RLSC_PORT_DEFAULT)
    else $error("port not default after reset");
  port_range_a: assert property (nv_port_wr |-> nv_port_data >= RLSC_PORT_MIN)
    else $error("out of range port stored");
  port_stored_a: assert property (net_out.port >= RLSC_PORT_MIN)
    else $error("stored port below range");
  port_live_a: assert property (nv_port_wr |=> net_out.port == $past(nv_port_data))
    else $error("new port not in use");
  route_local_a: assert property (((host_addr ^ own_addr) & net_mask) == 32'h0000_0000 |-> next_hop == host_addr)
    else $error("on-net host routed away");
  accept_conn_a: assert property (req_listen_s |-> taken_s)
    else $error("listening request not accepted");
  reject_busy_a: assert property (net_out.reject |-> net_in.conn_req && !net_out.listen && !net_out.accept)
    else $error("reject outside a session");
  close_idle_a: assert property (net_out.close |=> !net_out.listen && !net_out.accept)
    else $error("close did not end session");
  panel_gate_a: assert property (panel_accept |-> panel_evt)
    else $error("panel accepted without input");
  role_fixed_a: assert property (terminal_side_serial_role)
    else $error("serial role not terminal side");
  query_pass_a: assert property (resp_in.valid && resp_in.is_query |=>
    resp_out.valid && resp_out.data == $past(resp_in.data))
    else $error("query response not passed");
endmodule
bind rlsc_top rlsc_chk #(.MSGQ_DEPTH(MSGQ_DEPTH)) u_chk (.pclk(pclk), .presetn(presetn), .nv_port_wr(nv_port_wr),
  .nv_port_data(nv_port_data), .panel_evt(panel_evt), .panel_accept(panel_accept), .net_in(net_in),
  .net_out(net_out), .host_addr(host_addr), .own_addr(own_addr), .net_mask(net_mask), .next_hop(next_hop),
  .resp_in(resp_in), .resp_out(resp_out), .terminal_side_serial_role(terminal_side_serial_role));
`default_nettype wire

// ---- tb/rlsc_host_model.sv ----
// host computer model: command words and client socket events
// assumes pclk from the bench; outputs change just after rising edges
`timescale 1ns/1ns
`default_nettype none
module rlsc_host_model (
  input wire logic pclk,
  input wire rlsc_pkg::rlsc_net_out_t net_out,
  output logic cmd_valid,
  output logic [7:0] cmd_char,
  output var rlsc_pkg::rlsc_net_in_t net_in
);
  import rlsc_pkg::*;
  initial
  begin
    cmd_valid = 1'b0;
    cmd_char = 8'h00;
    net_in = '0;
  end
  // ==========
  // one word, one char per cycle, then line released
  task automatic send_word(input string s);
    for (int i = 0; i < s.len(); i++)
    begin
      @(posedge pclk);
      cmd_valid <= 1'b1;
      cmd_char <= s[i];
    end
    @(posedge pclk);
    cmd_valid <= 1'b0;
    cmd_char <= ~cmd_char;
  endtask
  // ==========
  // client connection request and hang-up
  task automatic connect(output logic acc, output logic rej);
    @(posedge pclk);
    net_in.conn_req <= 1'b1;
    @(negedge pclk);
    acc = net_out.accept;
    rej = net_out.reject;
    @(posedge pclk);
    net_in.conn_req <= 1'b0;
  endtask
  task automatic hang_up;
    @(posedge pclk);
    net_in.client_close <= 1'b1;
    @(posedge pclk);
    net_in.client_close <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- tb/rlsc_top_tb.sv ----
// bench for remote/local session control
// assumes rlsc_top, rlsc_host_model and the bound checker
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module rlsc_top_tb;
  import rlsc_pkg::*;
  localparam logic [47:0] ID = 48'h0000_1234_5678; // arbitrary value
  int n_fail = 0;
  int cmp_count = 0;
  logic pclk;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic nv_valid = 1'b0;
  logic [15:0] nv_port = 16'h0000;
  logic [31:0] nv_gateway = 32'h0000_0000;
  logic nv_port_wr;
  logic [15:0] nv_port_data;
  logic cmd_valid;
  logic [7:0] cmd_char;
  logic key_release = 1'b0;
  logic panel_evt = 1'b0;
  rlsc_net_in_t net_in;
  rlsc_net_out_t net_out;
  logic [31:0] host_addr = 32'h0b00_0009;
  logic [31:0] own_addr = 32'h0a00_0005;
  logic [31:0] net_mask = 32'hffff_ff00;
  logic [31:0] next_hop;
  rlsc_resp_t resp_in = '0;
  rlsc_resp_t resp_out;
  logic panel_accept;
  logic role;
  rlsc_top #(.HW_ID(ID)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .nv_valid(nv_valid),
    .nv_port(nv_port), .nv_gateway(nv_gateway), .nv_port_wr(nv_port_wr), .nv_port_data(nv_port_data),
    .cmd_valid(cmd_valid), .cmd_char(cmd_char), .key_release(key_release), .panel_evt(panel_evt),
    .net_in(net_in), .net_out(net_out), .host_addr(host_addr), .own_addr(own_addr), .net_mask(net_mask),
    .next_hop(next_hop), .resp_in(resp_in), .resp_out(resp_out), .panel_accept(panel_accept),
    .terminal_side_serial_role(role));
  rlsc_host_model host (.pclk(pclk), .net_out(net_out), .cmd_valid(cmd_valid), .cmd_char(cmd_char),
    .net_in(net_in));
  // ==========
  // apb master and helpers
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic resp_one(input logic q, input logic [7:0] d, input logic pass);
    @(posedge pclk);
    resp_in <= '{valid: 1'b1, is_query: q, data: d};
    @(posedge pclk);
    resp_in <= '0;
    #1 `CHK("resp_valid", pass, resp_out.valid)
    if (pass) `CHK("resp_data", d, resp_out.data)
  endtask
  // ==========
  // scenarios
  task automatic t_reset;
    logic [31:0] r;
    logic [7:0] a[6] = '{RLSC_OFF_PORT, RLSC_OFF_GW_PEND, RLSC_OFF_GW_ACT, RLSC_OFF_SERIAL, RLSC_OFF_STATUS, 8'h30};
    logic [31:0] x[6] = '{32'h0000_0da2, 0, 0, 32'h0060_2580, 32'h0000_0111, 0};
    foreach (a[i])
    begin
      apb(1'b0, a[i], 0, r);
      `CHK("reset_value", x[i], r)
    end
    apb(1'b1, RLSC_OFF_HWID_LO, 32'h0000_0000, r);
    `CHK("slverr", 1'b0, pslverr)
    apb(1'b0, RLSC_OFF_HWID_LO, 0, r);
    `CHK("hwid_lo", ID[31:0], r)
    `CHK("serial_role", 1'b1, role)
    `CHK("hop_no_gw", host_addr, next_hop)
    $display("t_reset done");
  endtask
  task automatic t_limits;
    logic [31:0] r;
    logic [7:0] a[8] = '{RLSC_OFF_PORT, RLSC_OFF_PORT, RLSC_OFF_PORT, RLSC_OFF_PORT,
      RLSC_OFF_SERIAL, RLSC_OFF_SERIAL, RLSC_OFF_SERIAL, RLSC_OFF_SERIAL};
    logic [31:0] v[8] = '{32'h0000_03ff, 32'h0000_0400, 32'h0001_0000, 32'h0000_ffff,
      32'h0060_012b, 32'h0060_012c, 32'h0061_c200, 32'h0061_c201};
    logic [31:0] x[8] = '{32'h0000_0da2, 32'h0000_0400, 32'h0000_0400, 32'h0000_ffff,
      32'h0060_2580, 32'h0060_012c, 32'h0061_c200, 32'h0061_c200};
    foreach (a[i])
    begin
      apb(1'b1, a[i], v[i], r);
      apb(1'b0, a[i], 0, r);
      `CHK("limit_readback", x[i], r)
      if (a[i] == RLSC_OFF_PORT) `CHK("live_port", x[i][15:0], net_out.port)
    end
    $display("t_limits done");
  endtask
  task automatic t_session;
    logic [31:0] r;
    logic acc;
    logic rej;
    apb(1'b1, RLSC_OFF_CTRL, 32'h0000_0003, r);
    @(posedge pclk);
    #1 `CHK("listen", 1'b1, net_out.listen)
    `CHK("listen_port", 16'hffff, net_out.port)
    host.connect(acc, rej);
    `CHK("accept", 2'b10, {acc, rej})
    host.connect(acc, rej);
    `CHK("reject", 2'b01, {acc, rej})
    apb(1'b0, RLSC_OFF_STATUS, 0, r);
    `CHK("busy_status", 19'h0_000c, {r[31:16], r[6:4]})
    host.hang_up();
    #1 `CHK("relisten", 1'b1, net_out.listen)
    host.connect(acc, rej);
    `CHK("accept_again", 2'b10, {acc, rej})
    apb(1'b1, RLSC_OFF_CTRL, 32'h0000_0002, r);
    #1 `CHK("close", 1'b1, net_out.close)
    apb(1'b0, RLSC_OFF_STATUS, 0, r);
    `CHK("idle_after_close", 4'h1, {net_out.listen, r[6:4]})
    $display("t_session done");
  endtask
  task automatic t_nv;
    logic [31:0] r;
    apb(1'b1, RLSC_OFF_GW_PEND, 32'h0a00_0001, r);
    apb(1'b0, RLSC_OFF_GW_ACT, 0, r);
    `CHK("gw_held", 32'h0000_0000, r)
    @(posedge pclk);
    nv_valid <= 1'b1;
    nv_port <= 16'h1388;
    nv_gateway <= 32'h0a00_0001;
    @(posedge pclk);
    nv_valid <= 1'b0;
    apb(1'b0, RLSC_OFF_PORT, 0, r);
    `CHK("port_restored", 32'h0000_1388, r)
    apb(1'b0, RLSC_OFF_GW_ACT, 0, r);
    `CHK("gw_active", 32'h0a00_0001, r)
    `CHK("hop_gw", 32'h0a00_0001, next_hop)
    @(posedge pclk);
    host_addr <= 32'h0a00_0009;
    @(posedge pclk);
    #1 `CHK("hop_direct", 32'h0a00_0009, next_hop)
    $display("t_nv done");
  endtask
  task automatic t_resp;
    logic [31:0] r;
    resp_one(1'b0, 8'h5a, 1'b0);
    apb(1'b0, RLSC_OFF_STATUS, 0, r);
    `CHK("msg_pending", 1'b1, r[9])
    resp_one(1'b1, 8'h3c, 1'b1);
    apb(1'b0, RLSC_OFF_MSGQ, 0, r);
    `CHK("msg_popped", 8'h5a, r[7:0])
    apb(1'b1, RLSC_OFF_CTRL, 32'h0000_0000, r);
    resp_one(1'b0, 8'ha5, 1'b1);
    $display("t_resp done");
  endtask
  task automatic t_states;
    logic [31:0] r;
    string w[11] = '{"remote ", "!", "ReMoTe ", "lockout ", "!", "LOCAL ", "foo ", "Remote ", "local ",
      "LOCAL ", "LOCKOUT "};
    logic [3:0] e[11] = '{4'h2, 4'h1, 4'h2, 4'h8, 4'h8, 4'h4, 4'h4, 4'h8, 4'h4, 4'h1, 4'h4};
    @(posedge pclk);
    panel_evt <= 1'b1;
    foreach (w[i])
    begin
      if (w[i] == "!")
      begin
        @(posedge pclk);
        key_release <= 1'b1;
        @(posedge pclk);
        key_release <= 1'b0;
      end
      else
        host.send_word(w[i]);
      apb(1'b0, RLSC_OFF_STATUS, 0, r);
      `CHK("op_state", e[i], r[3:0])
      `CHK("panel_accept", (e[i] == 4'h1 || e[i] == 4'h4), panel_accept)
    end
    $display("t_states done");
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========
  // clock, run and watchdog
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_limits();
    t_session();
    t_nv();
    t_resp();
    t_states();
    conclude();
  end
  initial
  begin
    #20000;
    n_fail++;
    $display("watchdog expired");
    conclude();
  end
endmodule
`default_nettype wire
